/* core/pfc_cfg_if.sv */
// scaling configuration carried between the top and the scaler
`timescale 1ns/1ps
`default_nettype none
interface pfc_cfg_if;
   logic [7:0] in_lo;
   logic [7:0] in_hi;
   logic [7:0] pct_lo;
   logic [7:0] pct_hi;
   logic [7:0] raw;
   logic [7:0] pct;
   modport src (output in_lo, in_hi, pct_lo, pct_hi, raw, input pct);
   modport scl (input in_lo, in_hi, pct_lo, pct_hi, raw, output pct);
endinterface
`default_nettype wire

/* core/pfc_params.svh */
// constants and rule summary for the feedback check and stop key block
// How it works
// R1: while running, assert feedback check when feedback drops below lower limit
// R2: check output stays on until feedback rises above upper limit
// R3: leaving run for stop clears the feedback check output
// R4: feedback check is a process signal, never a fault or trip
// R5: selector code 07 routes feedback check to output a, b or relay
// R6: stop key honoured in every source mode: brakes and resets faults
// R7: stop key enable 00 lets key act; otherwise only terminals or serial stop
// R8: stop method 01 lets motor coast, any other value ramps to 0 Hz
// R9: key braking uses the configured ramp; method picks ramp or coast stop
// R10: input between low and high thresholds maps linearly to feedback percentages
// R11: feedback selector 00 takes current input, 01 takes voltage input
// R12: reference factor scales display: 100 percent equals factor times hundred
// R13: normal direction raises frequency below reference, lowers it above
// R14: reference source 02 takes keypad entry or fixed reference values
// R15: controller, scaling and check work only when pid enable equals 01
// R16: check inactive after reset; method 01 coasts, 00 ramps
// R17: limits compared every cycle; check output changes two cycles after process_feedback crosses
`ifndef PFC_PARAMS_SVH
`define PFC_PARAMS_SVH
`define PFC_ADDR_STOP_EN 12'h000
`define PFC_ADDR_STOP_METH 12'h004
`define PFC_ADDR_PID_EN 12'h008
`define PFC_ADDR_FB_SEL 12'h00C
`define PFC_ADDR_REF_SRC 12'h010
`define PFC_ADDR_LIM_UP 12'h014
`define PFC_ADDR_LIM_LO 12'h018
`define PFC_ADDR_OUT_A 12'h01C
`define PFC_ADDR_OUT_B 12'h020
`define PFC_ADDR_RELAY 12'h024
`define PFC_ADDR_IN_LO 12'h028
`define PFC_ADDR_IN_HI 12'h02C
`define PFC_ADDR_PCT_LO 12'h030
`define PFC_ADDR_PCT_HI 12'h034
`define PFC_ADDR_SCALE 12'h038
`define PFC_ADDR_KEYREF 12'h03C
`define PFC_ADDR_STATUS 12'h040
`define PFC_ADDR_PV 12'h044
`define PFC_ADDR_DISP 12'h048
`define PFC_CODE_FBV 8'h07
`define PFC_CODE_ON 8'h00
`define PFC_CODE_PID 8'h01
`define PFC_CODE_COAST 8'h01
`define PFC_CODE_VOLT 8'h01
`define PFC_CODE_KEYPAD 8'h02
`define PFC_RST_UP 8'h64
`define PFC_RST_LO 8'h00
`define PFC_RST_IN_HI 8'h64
`define PFC_RST_PCT_HI 8'h64
`define PFC_RST_SCALE 8'h0A
`define PFC_PCT_FULL 8'h64
`endif

/* core/pfc_pkg.sv */
// types shared by the feedback check and stop key block
package pfc_pkg;
   typedef enum logic [1:0] {
      PFC_STOPPED = 2'b00,
      PFC_RUN = 2'b01,
      PFC_RAMP = 2'b10,
      PFC_COAST = 2'b11
   } pfc_state_e;
endpackage

/* core/pfc_scaler.sv */
// feedback scaler: raw input percent to feedback percent
`timescale 1ns/1ps
`default_nettype none
module pfc_scaler
   import pfc_pkg::*;
(
   pfc_cfg_if.scl cfg
);
   wire logic [8:0] span_in;
   wire logic [8:0] off_in;
   wire logic signed [9:0] span_out;
   wire logic signed [19:0] prod;
   wire logic signed [19:0] quot;
   wire logic signed [19:0] res;
   wire logic below;
   wire logic above;
   assign below = cfg.raw <= cfg.in_lo;
   assign above = cfg.raw >= cfg.in_hi;
   assign span_in = {1'b0, cfg.in_hi} - {1'b0, cfg.in_lo};
   assign off_in = {1'b0, cfg.raw} - {1'b0, cfg.in_lo};
   // swapped percentages give a negative span, inverting the feedback
   assign span_out = $signed({2'b00, cfg.pct_hi}) - $signed({2'b00, cfg.pct_lo}); // R10
   assign prod = span_out * $signed({11'h000, off_in});
   assign quot = (span_in == 9'h000) ? 20'sh00000 : prod / $signed({11'h000, span_in});
   assign res = quot + $signed({12'h000, cfg.pct_lo});
   assign cfg.pct = below ? cfg.pct_lo : (above ? cfg.pct_hi : res[7:0]); // R10
endmodule // pfc_scaler
`default_nettype wire

/* core/pfc_stopkey.sv */
// stop key qualification and stop method selection
`timescale 1ns/1ps
`default_nettype none
`include "pfc_params.svh"
module pfc_stopkey
   import pfc_pkg::*;
(
   input wire logic key_press,
   input wire logic term_stop,
   input wire logic [7:0] stop_key_enable,
   input wire logic [7:0] stop_key_method,
   output logic stop_req,
   output logic coast_sel,
   output logic fault_reset
);
   wire logic key_ok;
   // key works in every source mode; only its enable gates it
   assign key_ok = key_press && (stop_key_enable == `PFC_CODE_ON); // R6 R7
   assign stop_req = key_ok || term_stop; // R7
   assign fault_reset = key_ok || term_stop; // R6
   assign coast_sel = key_ok && (stop_key_method == `PFC_CODE_COAST); // R8 R16
endmodule // pfc_stopkey
`default_nettype wire

/* core/pfc_top.sv */
// feedback check output, pid scaling and keypad stop control
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "pfc_params.svh"
module pfc_top
   import pfc_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic start_cmd,
   input wire logic key_press,
   input wire logic term_stop,
   input wire logic ramp_done,
   input wire logic [7:0] current_input_terminal,
   input wire logic [7:0] voltage_input_terminal,
   input wire logic [7:0] fixed_reference,
   input wire logic fixed_ref_active,
   output logic feedback_check_out,
   output logic out_a,
   output logic out_b,
   output logic signalling_relay,
   output logic ramp_braking_stop,
   output logic coast_stop,
   output logic fault_reset,
   output logic freq_up,
   output logic freq_down,
   output logic running
);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0] stop_key_enable;
   logic [7:0] stop_key_method;
   logic [7:0] pid_enable;
   logic [7:0] feedback_input_sel;
   logic [7:0] reference_source_sel;
   logic [7:0] feedback_upper_limit;
   logic [7:0] feedback_lower_limit;
   logic [7:0] out_a_function_sel;
   logic [7:0] out_b_function_sel;
   logic [7:0] relay_function_sel;
   logic [7:0] input_low_threshold;
   logic [7:0] input_high_threshold;
   logic [7:0] feedback_pct_at_low_threshold;
   logic [7:0] feedback_pct_at_high_threshold;
   logic [7:0] reference_scale_factor;
   logic [7:0] keypad_reference;
   logic [7:0] process_feedback;
   pfc_state_e state;
   pfc_state_e next_state;
   logic fb_active;
   logic next_fb_active;
   pfc_cfg_if cfg ();
   wire logic pid_on;
   wire logic wr_en;
   wire logic rd_en;
   wire logic hit;
   wire logic stop_req;
   wire logic coast_sel;
   wire logic fault_rst;
   wire logic is_run;
   wire logic [7:0] reference;
   wire logic [15:0] disp_value;
   logic [31:0] rd_mux;

   ////////////////////////////////////////////////////////////////////////
   // apb: zero wait states; unmapped address answers pslverr
   function automatic logic addr_is(input logic [11:0] a, input logic [11:0] b);
      return a == b;
   endfunction
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign hit = (paddr[1:0] == 2'b00) && (paddr <= `PFC_ADDR_DISP);

   always_ff @(posedge core_clk) begin
      if (reset) begin
         stop_key_enable <= `PFC_CODE_ON;
         stop_key_method <= 8'h00;
         pid_enable <= 8'h00;
         feedback_input_sel <= 8'h00;
         reference_source_sel <= 8'h00;
         feedback_upper_limit <= `PFC_RST_UP;
         feedback_lower_limit <= `PFC_RST_LO;
         out_a_function_sel <= 8'h00;
         out_b_function_sel <= 8'h00;
         relay_function_sel <= 8'h00;
         input_low_threshold <= 8'h00;
         input_high_threshold <= `PFC_RST_IN_HI;
         feedback_pct_at_low_threshold <= 8'h00;
         feedback_pct_at_high_threshold <= `PFC_RST_PCT_HI;
         reference_scale_factor <= `PFC_RST_SCALE;
         keypad_reference <= 8'h00;
      end else if (wr_en) begin
         if (addr_is(paddr, `PFC_ADDR_STOP_EN)) stop_key_enable <= pwdata[7:0];
         if (addr_is(paddr, `PFC_ADDR_STOP_METH)) stop_key_method <= pwdata[7:0];
         if (addr_is(paddr, `PFC_ADDR_PID_EN)) pid_enable <= pwdata[7:0];
         if (addr_is(paddr, `PFC_ADDR_FB_SEL)) feedback_input_sel <= pwdata[7:0];
         if (addr_is(paddr, `PFC_ADDR_REF_SRC)) reference_source_sel <= pwdata[7:0];
         if (addr_is(paddr, `PFC_ADDR_LIM_UP)) feedback_upper_limit <= pwdata[7:0];
         if (addr_is(paddr, `PFC_ADDR_LIM_LO)) feedback_lower_limit <= pwdata[7:0];
         if (addr_is(paddr, `PFC_ADDR_OUT_A)) out_a_function_sel <= pwdata[7:0];
         if (addr_is(paddr, `PFC_ADDR_OUT_B)) out_b_function_sel <= pwdata[7:0];
         if (addr_is(paddr, `PFC_ADDR_RELAY)) relay_function_sel <= pwdata[7:0];
         if (addr_is(paddr, `PFC_ADDR_IN_LO)) input_low_threshold <= pwdata[7:0];
         if (addr_is(paddr, `PFC_ADDR_IN_HI)) input_high_threshold <= pwdata[7:0];
         if (addr_is(paddr, `PFC_ADDR_PCT_LO)) feedback_pct_at_low_threshold <= pwdata[7:0];
         if (addr_is(paddr, `PFC_ADDR_PCT_HI)) feedback_pct_at_high_threshold <= pwdata[7:0];
         if (addr_is(paddr, `PFC_ADDR_SCALE)) reference_scale_factor <= pwdata[7:0];
         if (addr_is(paddr, `PFC_ADDR_KEYREF)) keypad_reference <= pwdata[7:0];
      end
   end

   always_comb begin
      rd_mux = 32'h00000000;
      case (paddr)
         `PFC_ADDR_STOP_EN: rd_mux = {24'h000000, stop_key_enable};
         `PFC_ADDR_STOP_METH: rd_mux = {24'h000000, stop_key_method};
         `PFC_ADDR_PID_EN: rd_mux = {24'h000000, pid_enable};
         `PFC_ADDR_FB_SEL: rd_mux = {24'h000000, feedback_input_sel};
         `PFC_ADDR_REF_SRC: rd_mux = {24'h000000, reference_source_sel};
         `PFC_ADDR_LIM_UP: rd_mux = {24'h000000, feedback_upper_limit};
         `PFC_ADDR_LIM_LO: rd_mux = {24'h000000, feedback_lower_limit};
         `PFC_ADDR_OUT_A: rd_mux = {24'h000000, out_a_function_sel};
         `PFC_ADDR_OUT_B: rd_mux = {24'h000000, out_b_function_sel};
         `PFC_ADDR_RELAY: rd_mux = {24'h000000, relay_function_sel};
         `PFC_ADDR_IN_LO: rd_mux = {24'h000000, input_low_threshold};
         `PFC_ADDR_IN_HI: rd_mux = {24'h000000, input_high_threshold};
         `PFC_ADDR_PCT_LO: rd_mux = {24'h000000, feedback_pct_at_low_threshold};
         `PFC_ADDR_PCT_HI: rd_mux = {24'h000000, feedback_pct_at_high_threshold};
         `PFC_ADDR_SCALE: rd_mux = {24'h000000, reference_scale_factor};
         `PFC_ADDR_KEYREF: rd_mux = {24'h000000, keypad_reference};
         `PFC_ADDR_STATUS: rd_mux = {28'h0000000, fb_active, 1'b0, state};
         `PFC_ADDR_PV: rd_mux = {24'h000000, process_feedback};
         `PFC_ADDR_DISP: rd_mux = {16'h0000, disp_value};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= rd_en ? rd_mux : prdata;
         pready <= psel && !penable;
         pslverr <= psel && !penable && !hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // feedback path: select, scale, register once per cycle
   assign pid_on = pid_enable == `PFC_CODE_PID; // R15
   assign cfg.raw = (feedback_input_sel == `PFC_CODE_VOLT) ?
      voltage_input_terminal : current_input_terminal; // R11
   assign cfg.in_lo = input_low_threshold;
   assign cfg.in_hi = input_high_threshold;
   assign cfg.pct_lo = feedback_pct_at_low_threshold;
   assign cfg.pct_hi = feedback_pct_at_high_threshold;
   pfc_scaler u_scaler (
      .cfg(cfg)
   );
   // fixed values take priority over keypad entry
   assign reference = (reference_source_sel == `PFC_CODE_KEYPAD) ?
      (fixed_ref_active ? fixed_reference : keypad_reference) : 8'h00; // R14
   // display scaling: percent times factor (factor held in whole units)
   assign disp_value = 16'(process_feedback) * 16'(reference_scale_factor); // R12

   always_ff @(posedge core_clk) begin
      if (reset) begin
         process_feedback <= 8'h00;
      end else begin
         process_feedback <= pid_on ? cfg.pct : 8'h00; // R10 R15
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // run state and stop key
   pfc_stopkey u_stopkey (
      .key_press(key_press),
      .term_stop(term_stop),
      .stop_key_enable(stop_key_enable),
      .stop_key_method(stop_key_method),
      .stop_req(stop_req),
      .coast_sel(coast_sel),
      .fault_reset(fault_rst)
   );
   assign is_run = state == PFC_RUN;

   always_comb begin
      next_state = state;
      unique case (state)
         PFC_STOPPED: if (start_cmd && !stop_req) next_state = PFC_RUN;
         PFC_RUN: begin
            if (stop_req || !start_cmd) begin
               next_state = coast_sel ? PFC_COAST : PFC_RAMP; // R8 R9
            end
         end
         PFC_RAMP: if (ramp_done) next_state = PFC_STOPPED; // R9
         PFC_COAST: next_state = PFC_STOPPED; // R8
      endcase
   end

   // hysteresis: set below lower limit, clear above upper limit
   // status only; nothing here reaches a fault or trip path
   always_comb begin
      next_fb_active = fb_active;
      if (!is_run || !pid_on) begin
         next_fb_active = 1'b0; // R3 R15
      end else if (process_feedback < feedback_lower_limit) begin
         next_fb_active = 1'b1; // R1 R4
      end else if (process_feedback > feedback_upper_limit) begin
         next_fb_active = 1'b0; // R2
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state <= PFC_STOPPED;
         fb_active <= 1'b0; // R16
      end else begin
         state <= next_state;
         fb_active <= next_fb_active; // R17
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs
   always_ff @(posedge core_clk) begin
      if (reset) begin
         feedback_check_out <= 1'b0;
         out_a <= 1'b0;
         out_b <= 1'b0;
         signalling_relay <= 1'b0;
         ramp_braking_stop <= 1'b0;
         coast_stop <= 1'b0;
         fault_reset <= 1'b0;
         freq_up <= 1'b0;
         freq_down <= 1'b0;
         running <= 1'b0;
      end else begin
         feedback_check_out <= fb_active;
         out_a <= (out_a_function_sel == `PFC_CODE_FBV) && fb_active; // R5
         out_b <= (out_b_function_sel == `PFC_CODE_FBV) && fb_active; // R5
         signalling_relay <= (relay_function_sel == `PFC_CODE_FBV) && fb_active; // R5
         ramp_braking_stop <= next_state == PFC_RAMP; // R8
         coast_stop <= next_state == PFC_COAST; // R8
         fault_reset <= fault_rst; // R6
         freq_up <= pid_on && is_run && (process_feedback < reference); // R13
         freq_down <= pid_on && is_run && (process_feedback > reference); // R13
         running <= next_state == PFC_RUN;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   sequence s_low_run;
      is_run && pid_on && process_feedback < feedback_lower_limit;
   endsequence
   a_fb_set: assert property (@(posedge core_clk) disable iff (reset) // R1
      s_low_run |=> fb_active) else $error("check not set below lower limit");

   a_fb_hold: assert property (@(posedge core_clk) disable iff (reset) // R2
      fb_active && is_run && pid_on && process_feedback <= feedback_upper_limit
      |=> fb_active) else $error("check dropped inside hysteresis band");

   a_fb_stop: assert property (@(posedge core_clk) disable iff (reset) // R3
      !is_run |=> !fb_active) else $error("check active while not running");

   a_fb_out: assert property (@(posedge core_clk) disable iff (reset) // R17
      fb_active |=> feedback_check_out) else $error("check output late");

   a_route_a: assert property (@(posedge core_clk) disable iff (reset) // R5
      out_a_function_sel == `PFC_CODE_FBV && $stable(out_a_function_sel)
      |-> out_a == $past(fb_active)) else $error("output a not routed");

   a_key_block: assert property (@(posedge core_clk) disable iff (reset) // R7
      is_run && start_cmd && !term_stop && stop_key_enable != `PFC_CODE_ON
      |=> is_run) else $error("disabled key stopped drive");

   a_key_coast: assert property (@(posedge core_clk) disable iff (reset) // R8
      is_run && key_press && stop_key_enable == `PFC_CODE_ON
      && stop_key_method == `PFC_CODE_COAST |=> state == PFC_COAST ##1 coast_stop == 1'b0)
      else $error("coast stop not taken");

   a_key_ramp: assert property (@(posedge core_clk) disable iff (reset) // R9
      is_run && key_press && stop_key_enable == `PFC_CODE_ON
      && stop_key_method == `PFC_CODE_ON |=> state == PFC_RAMP)
      else $error("ramp stop not taken");

   a_pid_off: assert property (@(posedge core_clk) disable iff (reset) // R15
      !pid_on |=> process_feedback == 8'h00) else $error("scaling active without pid");

   ////////////////////////////////////////////////////////////////////////
   sequence s_key_on;
      key_press && stop_key_enable == `PFC_CODE_ON;
   endsequence

   a_route_b: assert property (@(posedge core_clk) disable iff (reset) // R5
      out_b_function_sel == `PFC_CODE_FBV && $stable(out_b_function_sel)
      |-> out_b == $past(fb_active)) else $error("output b not routed");

   a_route_relay: assert property (@(posedge core_clk) disable iff (reset) // R5
      relay_function_sel == `PFC_CODE_FBV && $stable(relay_function_sel)
      |-> signalling_relay == $past(fb_active)) else $error("relay not routed");

   a_key_fault: assert property (@(posedge core_clk) disable iff (reset) // R6
      s_key_on |=> fault_reset) else $error("key gave no fault reset");

   a_dir_up: assert property (@(posedge core_clk) disable iff (reset) // R13
      pid_on && is_run && process_feedback < reference |=> freq_up)
      else $error("frequency not raised");

   a_dir_down: assert property (@(posedge core_clk) disable iff (reset) // R13
      pid_on && is_run && process_feedback > reference |=> freq_down)
      else $error("frequency not lowered");

   a_fb_clear: assert property (@(posedge core_clk) disable iff (reset) // R2
      process_feedback > feedback_upper_limit && process_feedback >= feedback_lower_limit
      |=> !fb_active) else $error("check kept above upper limit");

   a_coast_end: assert property (@(posedge core_clk) disable iff (reset) // R8
      state == PFC_COAST |=> state == PFC_STOPPED) else $error("coast not ended");

   a_ramp_end: assert property (@(posedge core_clk) disable iff (reset) // R9
      state == PFC_RAMP && ramp_done |=> state == PFC_STOPPED)
      else $error("ramp not ended");

   a_stop_hold: assert property (@(posedge core_clk) disable iff (reset) // R7
      state == PFC_STOPPED && stop_req |=> !is_run)
      else $error("start during stop");

   a_ramp_out: assert property (@(posedge core_clk) disable iff (reset) // R8
      ramp_braking_stop == (state == PFC_RAMP)) else $error("ramp output wrong");

   a_coast_out: assert property (@(posedge core_clk) disable iff (reset) // R8
      coast_stop == (state == PFC_COAST)) else $error("coast output wrong");

   a_apb_ready: assert property (@(posedge core_clk) disable iff (reset)
      psel && !penable |=> pready) else $error("no ready in access phase");
endmodule // pfc_top
`default_nettype wire

/* tb/pfc_partner.sv */
// keypad and second motor starter model for the feedback check block
`timescale 1ns/1ps
`default_nettype none
module pfc_partner (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic press_req,
   input wire logic starter_cmd,
   output logic key_press,
   output logic starter_on
);
   ////////////////////////////////////////////////////////////////////////////////
   // key contact scanned once a cycle, so a press lands one edge late
   // starter contactor follows its command one edge late, like a real coil
   always_ff @(posedge core_clk) begin
      if (reset) begin
         key_press <= 1'b0;
         starter_on <= 1'b0;
      end else begin
         key_press <= press_req;
         starter_on <= starter_cmd;
      end
   end
endmodule // pfc_partner
`default_nettype wire

/* tb/tb.sv */
// self-checking testbench for the feedback check and stop key block
`timescale 1ns/1ps
`default_nettype none
`include "pfc_params.svh"
module tb;
   logic core_clk, reset, psel, penable, pwrite, start_cmd, ramp_done, term_stop, press_req;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, err, key_press, fbc, oa, ob, rel, rbs, cs, frst, fup, fdn, run, st_on;
   logic [7:0] cur_in, volt_in, fix_ref;
   logic fix_act;
   int n_fail, checks, cyc;

   pfc_top dut (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .start_cmd(start_cmd), .key_press(key_press), .term_stop(term_stop),
      .ramp_done(ramp_done), .current_input_terminal(cur_in), .voltage_input_terminal(volt_in),
      .fixed_reference(fix_ref), .fixed_ref_active(fix_act), .feedback_check_out(fbc),
      .out_a(oa), .out_b(ob), .signalling_relay(rel), .ramp_braking_stop(rbs),
      .coast_stop(cs), .fault_reset(frst), .freq_up(fup), .freq_down(fdn), .running(run));
   pfc_partner kp (.core_clk(core_clk), .reset(reset), .press_req(press_req),
      .starter_cmd(rel), .key_press(key_press), .starter_on(st_on));

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // ceiling well above the few hundred cycles the tests need
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         results();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR %s expected %0h seen %0h", w, e, s);
      end
   endtask
   task automatic bchk(input string w, input logic s, input logic e);
      chk(w, {31'h0, s}, {31'h0, e});
   endtask
   // one apb transfer; slave latency taken from pready, not assumed
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask
   task automatic rchk(input string w, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(w, rd, e);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic press();
      @(posedge core_clk);
      press_req <= 1'b1;
      tick(2);
   endtask
   task automatic drive_in(input logic [7:0] c, input logic [7:0] v, input logic s);
      @(posedge core_clk);
      cur_in <= c;
      volt_in <= v;
      start_cmd <= s;
   endtask
   task automatic release_all();
      @(posedge core_clk);
      press_req <= 1'b0;
      term_stop <= 1'b0;
      start_cmd <= 1'b0;
      ramp_done <= 1'b1;
      repeat (2) @(posedge core_clk);
      ramp_done <= 1'b0;
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {psel, penable, pwrite, start_cmd, ramp_done, term_stop, press_req} = '0;
      {paddr, pwdata, cur_in, volt_in, fix_ref, fix_act} = '0;
      reset = 1'b1;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      rchk("stop_key_enable", `PFC_ADDR_STOP_EN, 32'h0);
      rchk("stop_key_method", `PFC_ADDR_STOP_METH, 32'h0);
      rchk("upper limit", `PFC_ADDR_LIM_UP, {24'h0, `PFC_RST_UP});
      bchk("check after reset", fbc, 1'b0);
      apb(1'b1, `PFC_ADDR_STOP_EN, 32'hFFFF_FFA5);
      rchk("enable readback", `PFC_ADDR_STOP_EN, 32'h0000_00A5);
      wr(`PFC_ADDR_STOP_EN, 8'h00);
      apb(1'b1, 12'h100, 32'h55);
      bchk("unmapped error", err, 1'b1);
      $display("test registers done");
      // scaling: 40 over a 20..100 window is 25 percent
      wr(`PFC_ADDR_PID_EN, `PFC_CODE_PID);
      wr(`PFC_ADDR_IN_LO, 8'h14);
      drive_in(8'h28, 8'h5A, 1'b0);
      rchk("feedback", `PFC_ADDR_PV, 32'h19);
      wr(`PFC_ADDR_PCT_LO, 8'h64);
      wr(`PFC_ADDR_PCT_HI, 8'h00);
      rchk("inverted feedback", `PFC_ADDR_PV, 32'h4B);
      wr(`PFC_ADDR_PCT_LO, 8'h00);
      wr(`PFC_ADDR_PCT_HI, 8'h64);
      drive_in(8'h5A, 8'h28, 1'b0);
      wr(`PFC_ADDR_FB_SEL, `PFC_CODE_VOLT);
      rchk("voltage feedback", `PFC_ADDR_PV, 32'h19);
      wr(`PFC_ADDR_SCALE, 8'h32);
      rchk("display", `PFC_ADDR_DISP, 32'h4E2);
      wr(`PFC_ADDR_FB_SEL, 8'h00);
      wr(`PFC_ADDR_IN_LO, 8'h00);
      wr(`PFC_ADDR_SCALE, `PFC_RST_SCALE);
      $display("test scaling done");
      // hysteresis between 30 and 70 percent
      wr(`PFC_ADDR_LIM_LO, 8'h1E);
      wr(`PFC_ADDR_LIM_UP, 8'h46);
      wr(`PFC_ADDR_OUT_A, `PFC_CODE_FBV);
      wr(`PFC_ADDR_OUT_B, `PFC_CODE_FBV);
      wr(`PFC_ADDR_RELAY, `PFC_CODE_FBV);
      wr(`PFC_ADDR_REF_SRC, `PFC_CODE_KEYPAD);
      wr(`PFC_ADDR_KEYREF, 8'h32);
      drive_in(8'h14, 8'h00, 1'b0);
      tick(5);
      bchk("check while stopped", fbc, 1'b0);
      drive_in(8'h14, 8'h00, 1'b1);
      tick(5);
      bchk("running", run, 1'b1);
      bchk("check low", fbc, 1'b1);
      chk("outputs", {oa, ob, rel, st_on}, 4'hF);
      bchk("no fault", frst, 1'b0);
      chk("direction low", {fup, fdn}, 2'b10);
      rchk("status", `PFC_ADDR_STATUS, 32'h9);
      drive_in(8'h32, 8'h00, 1'b1);
      tick(5);
      bchk("check between limits", fbc, 1'b1);
      drive_in(8'h50, 8'h00, 1'b1);
      tick(2);
      bchk("check before update", fbc, 1'b1);
      tick(1);
      bchk("check above upper", fbc, 1'b0);
      tick(2);
      chk("direction high", {fup, fdn}, 2'b01);
      @(posedge core_clk);
      fix_ref <= 8'h5A;
      fix_act <= 1'b1;
      tick(2);
      chk("fixed reference", {fup, fdn}, 2'b10);
      @(posedge core_clk);
      fix_act <= 1'b0;
      drive_in(8'h14, 8'h00, 1'b1);
      tick(5);
      bchk("check again", fbc, 1'b1);
      wr(`PFC_ADDR_PID_EN, 8'h00);
      tick(4);
      bchk("check pid off", fbc, 1'b0);
      wr(`PFC_ADDR_PID_EN, `PFC_CODE_PID);
      tick(4);
      drive_in(8'h14, 8'h00, 1'b0);
      tick(1);
      bchk("ramp on start drop", rbs, 1'b1);
      tick(3);
      bchk("check cleared on stop", fbc, 1'b0);
      release_all();
      bchk("stopped", run, 1'b0);
      $display("test feedback check done");
      // keypad stop key: ramp, coast, then disabled
      drive_in(8'h14, 8'h00, 1'b1);
      tick(3);
      press();
      chk("key ramp", {rbs, cs, run, frst}, 4'b1001);
      release_all();
      wr(`PFC_ADDR_STOP_METH, `PFC_CODE_COAST);
      drive_in(8'h14, 8'h00, 1'b1);
      tick(3);
      press();
      chk("key coast", {rbs, cs, run}, 3'b010);
      tick(1);
      chk("coast ended", {cs, run}, 2'b00);
      release_all();
      wr(`PFC_ADDR_STOP_EN, 8'h01);
      drive_in(8'h14, 8'h00, 1'b1);
      tick(3);
      press();
      tick(1);
      chk("key disabled", {run, frst}, 2'b10);
      @(posedge core_clk);
      term_stop <= 1'b1;
      tick(2);
      chk("terminal stop", {run, frst}, 2'b01);
      release_all();
      $display("test stop key done");
      results();
   end
endmodule // tb
`default_nettype wire
